// ### clk_select.v
// Master and programmable clock selection with AHB-Lite registers and write protection
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "clk_sel_defs.vh"
module clk_select #(
   parameter [23:0] WP_KEY = 24'h5a5a5a, // Arbitrary access key value
   parameter NUM_PCK = 3
) (
   input wire REF_CLK,
   input wire RST_N,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   input wire SLOW_CLK_IN,
   input wire MAIN_CLK_IN,
   input wire PLL_CLK_IN,
   input wire PLL_LOCK_IN,
   output reg MCK_OUT,
   output reg [2:0] PCK_OUT,
   output reg [31:0] PERIPH_CLK_EN,
   output reg IRQ
);
   localparam ST_RUN = 2'h0;
   localparam ST_DRAIN = 2'h1;
   localparam ST_SETTLE = 2'h2;

   // Picks one of four levels by source code; used for levels and ticks alike
   function pick;
      input [1:0] sel;
      input [3:0] v;
      begin
         pick = v[sel];
      end
   endfunction

   // Protected offsets
   function is_prot;
      input [8:0] a;
      begin
         case (a)
            `OFS_SYS_CLK_EN, `OFS_SYS_CLK_DIS, `OFS_PER_CLK_EN, `OFS_PER_CLK_DIS,
            `OFS_MAIN_OSC, `OFS_PLL_CFG, `OFS_MCK_CFG, `OFS_PCK0_CFG,
            `OFS_PCK1_CFG, `OFS_PCK2_CFG, `OFS_FAST_MODE, `OFS_FAST_POL,
            `OFS_OSC_CAL: is_prot = 1'b1;
            default: is_prot = 1'b0;
         endcase
      end
   endfunction

   wire slow_lvl, main_lvl, pll_lvl, lock_lvl;
   wire slow_rise, main_rise, pll_rise;

   src_sync u_slow (.clk(REF_CLK), .rst_n(RST_N), .src_in(SLOW_CLK_IN),
      .lvl_r(slow_lvl), .rise(slow_rise));
   src_sync u_main (.clk(REF_CLK), .rst_n(RST_N), .src_in(MAIN_CLK_IN),
      .lvl_r(main_lvl), .rise(main_rise));
   src_sync u_pll (.clk(REF_CLK), .rst_n(RST_N), .src_in(PLL_CLK_IN),
      .lvl_r(pll_lvl), .rise(pll_rise));
   src_sync u_lock (.clk(REF_CLK), .rst_n(RST_N), .src_in(PLL_LOCK_IN),
      .lvl_r(lock_lvl), .rise());

   // Register state
   reg [31:0] mck_cfg_r, pll_cfg_r, main_osc_r, fast_mode_r, fast_pol_r, osc_cal_r;
   reg [31:0] pck_cfg_r [0:2];
   reg [2:0] pck_en_r;
   reg [2:0] pck_rdy_r;
   reg [31:0] int_mask_r;
   reg write_protect_on_r, write_violation_flag_r;
   reg [15:0] violation_source_field_r;
   reg mck_rdy_r;

   // Data phase capture
   reg dp_wr_r;
   reg [8:0] dp_addr_r;
   wire ap_valid = HSEL & HTRANS[1] & HREADY;
   wire wr = dp_wr_r;
   wire blocked = wr & write_protect_on_r & is_prot(dp_addr_r);
   wire wr_ok = wr & ~blocked;

   // Master switch state
   reg [1:0] st_r;
   reg [1:0] cur_sel_r;
   reg [2:0] cur_prescaler_r;
   reg gate_r;
   reg [3:0] settle_r;
   wire [1:0] clock_source_select = mck_cfg_r[`SRC_SELECT_LSB +: 2];
   wire [2:0] prescaler_field = mck_cfg_r[`PRESCALER_LSB +: 3];
   wire unlocked = (clock_source_select == `SRC_PLL) & ~lock_lvl;
   wire [1:0] tgt_sel = unlocked ? `SRC_SLOW : clock_source_select;
   wire [3:0] src_lvls = {1'b0, pll_lvl, main_lvl, slow_lvl};
   wire [3:0] src_rises = {1'b0, pll_rise, main_rise, slow_rise};
   wire mck_div;

   pow2_div u_mdiv (.clk(REF_CLK), .rst_n(RST_N),
      .src_lvl(pick(cur_sel_r, src_lvls)), .src_rise(pick(cur_sel_r, src_rises)),
      .prescaler_field(cur_prescaler_r), .div_r(mck_div));

   // Programmable clock dividers; code 3 takes the master clock, passed only undivided as its tick is tied low
   wire [2:0] pck_div;
   wire [2:0] pck_rise;
   genvar g;
   generate
      for (g = 0; g < NUM_PCK; g = g + 1) begin : g_pck
         wire [3:0] lv = {MCK_OUT, pll_lvl, main_lvl, slow_lvl};
         wire [3:0] rs = {1'b0, pll_rise, main_rise, slow_rise};
         wire [1:0] sel = pck_cfg_r[g][`SRC_SELECT_LSB +: 2];
         assign pck_rise[g] = pick(sel, rs);
         pow2_div u_pdiv (.clk(REF_CLK), .rst_n(RST_N),
            .src_lvl(pick(sel, lv)), .src_rise(pck_rise[g]),
            .prescaler_field(pck_cfg_r[g][`PRESCALER_LSB +: 3]),
            .div_r(pck_div[g]));
      end
   endgenerate

   wire [31:0] status = {21'h0, pck_rdy_r, 4'h0, mck_rdy_r, 1'b0, lock_lvl, 1'b0};

   // Bus address phase: zero wait states, read data registered for the data phase
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 9'h000;
         HRDATA <= 32'h0000_0000;
         HREADYOUT <= 1'b0;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         dp_wr_r <= ap_valid & HWRITE;
         dp_addr_r <= {HADDR[8:2], 2'h0};
         HRDATA <= 32'h0000_0000;
         if (ap_valid & ~HWRITE) begin
            case ({HADDR[8:2], 2'h0})
               `OFS_SYS_CLK_STAT: HRDATA <= {21'h0, pck_en_r, 8'h00};
               `OFS_PER_CLK_STAT: HRDATA <= PERIPH_CLK_EN;
               `OFS_MAIN_OSC: HRDATA <= main_osc_r;
               `OFS_PLL_CFG: HRDATA <= pll_cfg_r;
               `OFS_MCK_CFG: HRDATA <= mck_cfg_r;
               `OFS_PCK0_CFG: HRDATA <= pck_cfg_r[0];
               `OFS_PCK1_CFG: HRDATA <= pck_cfg_r[1];
               `OFS_PCK2_CFG: HRDATA <= pck_cfg_r[2];
               `OFS_STATUS: HRDATA <= status;
               `OFS_INT_MASK: HRDATA <= int_mask_r;
               `OFS_FAST_MODE: HRDATA <= fast_mode_r;
               `OFS_FAST_POL: HRDATA <= fast_pol_r;
               `OFS_PROT_MODE: HRDATA <= {WP_KEY, 7'h00, write_protect_on_r};
               `OFS_PROT_STAT:
                  HRDATA <= {8'h00, violation_source_field_r, 7'h00, write_violation_flag_r};
               `OFS_OSC_CAL: HRDATA <= osc_cal_r;
               default: HRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Register writes in the data phase; protected writes are dropped and recorded
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         mck_cfg_r <= `RST_MCK_CFG;
         pll_cfg_r <= `RST_PLL_CFG;
         main_osc_r <= `RST_MAIN_OSC;
         fast_mode_r <= 32'h0000_0000;
         fast_pol_r <= 32'h0000_0000;
         osc_cal_r <= `RST_OSC_CAL;
         pck_cfg_r[0] <= `RST_PCK_CFG;
         pck_cfg_r[1] <= `RST_PCK_CFG;
         pck_cfg_r[2] <= `RST_PCK_CFG;
         pck_en_r <= 3'h0;
         PERIPH_CLK_EN <= 32'h0000_0000;
         int_mask_r <= 32'h0000_0000;
         write_protect_on_r <= 1'b0;
         write_violation_flag_r <= 1'b0;
         violation_source_field_r <= 16'h0000;
      end else begin
         // Set wins over a keyed clear arriving in the same cycle
         if (wr_ok && dp_addr_r == `OFS_PROT_MODE && HWDATA[31:8] == WP_KEY) begin
            write_protect_on_r <= HWDATA[`PROTECT_ON_BIT];
            write_violation_flag_r <= 1'b0;
         end
         if (blocked) begin
            write_violation_flag_r <= 1'b1;
            violation_source_field_r <= {7'h00, dp_addr_r};
         end
         if (wr_ok) begin
            case (dp_addr_r)
               `OFS_SYS_CLK_EN: pck_en_r <= pck_en_r | HWDATA[`PCK_EN_LSB +: 3];
               `OFS_SYS_CLK_DIS: pck_en_r <= pck_en_r & ~HWDATA[`PCK_EN_LSB +: 3];
               `OFS_PER_CLK_EN: PERIPH_CLK_EN <= PERIPH_CLK_EN | HWDATA;
               `OFS_PER_CLK_DIS: PERIPH_CLK_EN <= PERIPH_CLK_EN & ~HWDATA;
               `OFS_MAIN_OSC: main_osc_r <= HWDATA;
               `OFS_PLL_CFG: pll_cfg_r <= HWDATA;
               `OFS_MCK_CFG: mck_cfg_r <= {25'h0, HWDATA[`PRESCALER_LSB +: 3], 2'h0, HWDATA[1:0]};
               `OFS_PCK0_CFG: pck_cfg_r[0] <= {25'h0, HWDATA[6:4], 2'h0, HWDATA[1:0]};
               `OFS_PCK1_CFG: pck_cfg_r[1] <= {25'h0, HWDATA[6:4], 2'h0, HWDATA[1:0]};
               `OFS_PCK2_CFG: pck_cfg_r[2] <= {25'h0, HWDATA[6:4], 2'h0, HWDATA[1:0]};
               `OFS_INT_EN: int_mask_r <= int_mask_r | HWDATA;
               `OFS_INT_DIS: int_mask_r <= int_mask_r & ~HWDATA;
               `OFS_FAST_MODE: fast_mode_r <= HWDATA;
               `OFS_FAST_POL: fast_pol_r <= HWDATA;
               `OFS_OSC_CAL: osc_cal_r <= HWDATA;
               default: ;
            endcase
         end
      end
   end

   // Master switch: drain old clock low, change over, settle, then ungate on a low phase
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         st_r <= ST_RUN;
         cur_sel_r <= `SRC_MAIN;
         cur_prescaler_r <= 3'h0;
         gate_r <= 1'b1;
         settle_r <= 4'h0;
         mck_rdy_r <= 1'b1;
      end else begin
         case (st_r)
            ST_RUN: begin
               mck_rdy_r <= ~unlocked;
               if (tgt_sel != cur_sel_r || prescaler_field != cur_prescaler_r) begin
                  mck_rdy_r <= 1'b0;
                  st_r <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               mck_rdy_r <= 1'b0;
               if (!mck_div) begin
                  gate_r <= 1'b0;
                  cur_sel_r <= tgt_sel;
                  cur_prescaler_r <= prescaler_field;
                  settle_r <= 4'h0;
                  st_r <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               mck_rdy_r <= 1'b0;
               if (settle_r != `SW_SLOW_CYCLES) begin
                  if (slow_rise)
                     settle_r <= settle_r + 4'h1;
               end else if (!mck_div) begin
                  // Divided output may need up to 32 new-source edges before this low phase
                  gate_r <= 1'b1;
                  st_r <= ST_RUN;
                  // A rewrite during the switch leaves ready low so the next one starts at once
                  mck_rdy_r <= (tgt_sel == cur_sel_r) & ~unlocked &
                     (prescaler_field == cur_prescaler_r);
               end
            end
            default: st_r <= ST_RUN;
         endcase
      end
   end

   // Outputs and programmable clock ready flags
   integer i;
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         MCK_OUT <= 1'b0;
         PCK_OUT <= 3'h0;
         pck_rdy_r <= 3'h0;
         IRQ <= 1'b0;
      end else begin
         MCK_OUT <= gate_r & mck_div;
         for (i = 0; i < NUM_PCK; i = i + 1) begin
            // No glitch guard here; software disables before reconfiguring
            PCK_OUT[i] <= pck_en_r[i] & pck_div[i];
            if (!pck_en_r[i])
               pck_rdy_r[i] <= 1'b0;
            else if (pck_rise[i])
               pck_rdy_r[i] <= 1'b1;
         end
         IRQ <= |(status & int_mask_r);
      end
   end
endmodule
`default_nettype wire

// ### clk_sel_defs.vh
// Register offsets, field positions, reset values and timing counts for the clock selector
`ifndef CLK_SEL_DEFS_VH
`define CLK_SEL_DEFS_VH

// Register byte offsets
`define OFS_SYS_CLK_EN 9'h000
`define OFS_SYS_CLK_DIS 9'h004
`define OFS_SYS_CLK_STAT 9'h008
`define OFS_PER_CLK_EN 9'h010
`define OFS_PER_CLK_DIS 9'h014
`define OFS_PER_CLK_STAT 9'h018
`define OFS_MAIN_OSC 9'h020
`define OFS_PLL_CFG 9'h028
`define OFS_MCK_CFG 9'h030
`define OFS_PCK0_CFG 9'h040
`define OFS_PCK1_CFG 9'h044
`define OFS_PCK2_CFG 9'h048
`define OFS_INT_EN 9'h060
`define OFS_INT_DIS 9'h064
`define OFS_STATUS 9'h068
`define OFS_INT_MASK 9'h06c
`define OFS_FAST_MODE 9'h070
`define OFS_FAST_POL 9'h074
`define OFS_PROT_MODE 9'h0e4
`define OFS_PROT_STAT 9'h0e8
`define OFS_OSC_CAL 9'h110

// Clock source select encodings
`define SRC_SLOW 2'h0
`define SRC_MAIN 2'h1
`define SRC_PLL 2'h2
`define SRC_MCK 2'h3

// Field positions
`define SRC_SELECT_LSB 0
`define PRESCALER_LSB 4
`define PCK_EN_LSB 8
`define STAT_LOCK_BIT 1
`define STAT_MCK_READY_BIT 3
`define STAT_PCK_READY_LSB 8
`define PROTECT_ON_BIT 0
`define WP_KEY_LSB 8
`define VIOLATION_SRC_LSB 8

// Reset values
`define RST_MCK_CFG 32'h0000_0001
`define RST_PCK_CFG 32'h0000_0000
`define RST_PLL_CFG 32'h0000_3f00
`define RST_MAIN_OSC 32'h0000_0001
`define RST_OSC_CAL 32'h0040_4040

// Master switch settle time in slow clock periods, undivided worst case
`define SW_SLOW_CYCLES 4'h5

`endif

// ### src_sync.v
// Two-flop synchroniser and rising-edge tick for one incoming source clock
`timescale 1ns/10ps
`default_nettype none
module src_sync (
   input wire clk,
   input wire rst_n,
   input wire src_in,
   output reg lvl_r,
   output wire rise
);
   reg meta_r;
   reg prev_r;

   // Only the second flop and later stages are looked at
   always @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         lvl_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= src_in;
         lvl_r <= meta_r;
         prev_r <= lvl_r;
      end
   end

   assign rise = lvl_r & ~prev_r;
endmodule
`default_nettype wire

// ### pow2_div.v
// Power-of-two divider, 1 through 64, running on rising ticks of its source
`timescale 1ns/10ps
`default_nettype none
module pow2_div (
   input wire clk,
   input wire rst_n,
   input wire src_lvl,
   input wire src_rise,
   input wire [2:0] prescaler_field,
   output reg div_r
);
   reg [5:0] cnt_r;
   wire [2:0] p;

   // Code 7 is reserved and behaves as 64
   assign p = (prescaler_field == 3'h7) ? 3'h6 : prescaler_field;

   // Counter bit p-1 toggles every 2^(p-1) source edges, giving a period of 2^p
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= 6'h00;
         div_r <= 1'b0;
      end else begin
         if (src_rise)
            cnt_r <= cnt_r + 6'h01;
         if (p == 3'h0)
            div_r <= src_lvl;
         else
            div_r <= cnt_r[p - 3'h1];
      end
   end
endmodule
`default_nettype wire

// ### clk_select_asserts.sv
// Port-level assertions for the clock selector
`timescale 1ns/10ps
`default_nettype none
module clk_select_asserts (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic MCK_OUT,
   input wire logic [2:0] PCK_OUT,
   input wire logic [31:0] PERIPH_CLK_EN
);
   // Address phases taken by the slave
   wire rd = HSEL && HTRANS[1] && HREADY && !HWRITE;
   wire wr = HSEL && HTRANS[1] && HREADY && HWRITE;
   wire [8:0] a = HADDR[8:0];
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // Enables move only two edges after a write to the set or clear word
   sequence s_no_per_wr;
      !(wr && (a == 9'h010 || a == 9'h014)) ##1 1'b1;
   endsequence
   sequence s_mck_rise;
      !MCK_OUT ##1 MCK_OUT;
   endsequence
   sequence s_mck_fall;
      MCK_OUT ##1 !MCK_OUT;
   endsequence
   AST_RDY_REL: assert property ($rose(RST_N) |-> !HREADYOUT ##1 HREADYOUT)
      else $error("bus ready not raised one edge after reset release");
   AST_RDY_HOLD: assert property ($past(RST_N) |-> HREADYOUT)
      else $error("bus ready dropped in operation");
   AST_HRESP: assert property (HRESP == 1'b0)
      else $error("error response seen");
   AST_RD_IDLE: assert property (!rd |=> HRDATA == 32'h0)
      else $error("read data outside a read data phase");
   AST_RST_OUT: assert property ($rose(RST_N) |-> PCK_OUT == 3'h0 && PERIPH_CLK_EN == 32'h0)
      else $error("clock outputs not off after reset");
   AST_PER_CAUSE: assert property (s_no_per_wr |=> $stable(PERIPH_CLK_EN))
      else $error("peripheral enables changed without a write");
   // Sources are slower than a quarter of the bus clock, so a level lasts two edges
   AST_MCK_HI: assert property (s_mck_rise |=> MCK_OUT)
      else $error("runt high pulse on master clock");
   AST_MCK_LO: assert property (s_mck_fall |=> !MCK_OUT)
      else $error("runt low pulse on master clock");
   AST_SCSR: assert property (rd && a == 9'h008 |=> (HRDATA & ~32'h700) == 32'h0)
      else $error("status of output clocks has stray bits");
endmodule
`default_nettype wire

// ### tb_top.sv
// Bench for the clock selector: bus tasks and directed scenarios
`timescale 1ns/10ps
`default_nettype none
`include "clk_sel_defs.vh"
module tb_top;
   localparam logic [23:0] key = 24'h5a5a5a; // Arbitrary key value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic slow = 1'b0;
   logic main = 1'b0;
   logic pll = 1'b0;
   logic lock = 1'b1;
   wire [31:0] hrdata;
   wire [31:0] per_en;
   wire [2:0] pck;
   wire rdy;
   wire mck;
   wire irq;
   wire [3:0] cv = {mck, pck};
   int num_errors = 0;
   int cmp_count = 0;
   logic [31:0] q;
   int per [3] = '{21, 9, 5}; // Source periods in bus cycles: slow, main, pll
   logic [8:0] pr [11] = '{9'h000, 9'h004, 9'h010, 9'h014, 9'h020, 9'h028, 9'h030,
      9'h040, 9'h070, 9'h074, 9'h110};
   // Sources offset by a quarter period so no edge meets a bus clock edge
   initial forever #50 clk = ~clk;
   initial #25 forever #1050 slow = ~slow;
   initial #25 forever #450 main = ~main;
   initial #25 forever #250 pll = ~pll;
   clk_select #(.WP_KEY(key), .NUM_PCK(3)) clk_select_i (
      .REF_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata),
      .HREADYOUT(rdy), .HRESP(), .SLOW_CLK_IN(slow), .MAIN_CLK_IN(main),
      .PLL_CLK_IN(pll), .PLL_LOCK_IN(lock), .MCK_OUT(mck), .PCK_OUT(pck),
      .PERIPH_CLK_EN(per_en), .IRQ(irq));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single transfer; the leading idle cycle avoids reading a word just written
   task automatic xfer(input logic w, input logic [8:0] ofs, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {23'h0, ofs};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      q = hrdata;
   endtask
   task automatic rc(input logic [8:0] ofs, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, ofs, 32'h0);
      chk($sformatf("reg %h", ofs), e, q & m);
   endtask
   // Polls status under a bounded count
   task automatic wbit(input logic [31:0] m, input logic [31:0] e);
      int n;
      xfer(1'b0, `OFS_STATUS, 32'h0);
      for (n = 0; n < 600 && (q & m) !== e; n++) xfer(1'b0, `OFS_STATUS, 32'h0);
      chk("status", e, q & m);
   endtask
   // Cycles between two sampled rises of a clock output
   task automatic meas(input int i, input int e);
      int n;
      int p;
      for (n = 0; n < 3000 && cv[i] !== 1'b0; n++) @(posedge clk);
      for (n = 0; n < 3000 && cv[i] !== 1'b1; n++) @(posedge clk);
      p = 0;
      for (n = 1; n >= 0; n--)
         while (p < 3000 && cv[i] === n[0]) begin
            @(posedge clk);
            p++;
         end
      chk("period", e, p);
   endtask
   task print_verdict;
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about half a millisecond
   initial begin
      #5_000_000;
      num_errors++;
      print_verdict();
   end
   // Main sequence
   initial begin
      int i;
      int c;
      int t0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rc(`OFS_MCK_CFG, 32'hffff_ffff, `RST_MCK_CFG);
      rc(`OFS_STATUS, 32'h70a, 32'h00a);
      rc(`OFS_SYS_CLK_STAT, 32'hffff_ffff, 32'h0);
      for (i = 0; i < 3; i++) rc(9'(`OFS_PCK0_CFG + 4 * i), 32'hffff_ffff, 32'h0);
      rc(`OFS_PLL_CFG, 32'hffff_ffff, `RST_PLL_CFG);
      rc(9'h00c, 32'hffff_ffff, 32'h0);
      meas(3, per[1]);
      xfer(1'b1, `OFS_MCK_CFG, 32'h11);
      rc(`OFS_STATUS, 32'h8, 32'h0);
      wbit(32'h8, 32'h8);
      meas(3, 2 * per[1]);
      // Toward slow: source first; bound is the worst case with prescaler on
      t0 = int'($time / 100);
      xfer(1'b1, `OFS_MCK_CFG, 32'h10);
      wbit(32'h8, 32'h8);
      chk("switch", 32'h1, int'($time / 100) - t0 <= 5 + 95 + 64 * 21);
      xfer(1'b1, `OFS_MCK_CFG, 32'h00);
      wbit(32'h8, 32'h8);
      meas(3, per[0]);
      // Toward PLL: prescaler first, then source code 2
      xfer(1'b1, `OFS_MCK_CFG, 32'h20);
      wbit(32'h8, 32'h8);
      xfer(1'b1, `OFS_MCK_CFG, 32'h22);
      wbit(32'h8, 32'h8);
      meas(3, 4 * per[2]);
      lock <= 1'b0;
      repeat (6) @(posedge clk);
      rc(`OFS_STATUS, 32'ha, 32'h0);
      meas(3, 4 * per[0]);
      lock <= 1'b1;
      wbit(32'ha, 32'ha);
      // Ready flag reaches the interrupt line only while its mask bit is set
      xfer(1'b1, `OFS_INT_EN, 32'h8);
      rc(`OFS_INT_MASK, 32'hffff_ffff, 32'h8);
      chk("irq", 32'h1, {31'h0, irq});
      xfer(1'b1, `OFS_INT_DIS, 32'h8);
      rc(`OFS_INT_MASK, 32'hffff_ffff, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      // Outputs in turn: disable, configure, enable, wait ready, measure
      for (i = 0; i < 7; i++) begin
         c = i % 3;
         xfer(1'b1, `OFS_SYS_CLK_DIS, 32'h100 << c);
         rc(`OFS_STATUS, 32'h100 << c, 32'h0);
         xfer(1'b1, 9'(`OFS_PCK0_CFG + 4 * c), 32'(i * 16 + c));
         xfer(1'b1, `OFS_SYS_CLK_EN, 32'h100 << c);
         xfer(1'b1, `OFS_SYS_CLK_DIS, 32'h0);
         rc(`OFS_SYS_CLK_STAT, 32'h100 << c, 32'h100 << c);
         wbit(32'h100 << c, 32'h100 << c);
         meas(c, per[c] << i);
      end
      xfer(1'b1, `OFS_SYS_CLK_DIS, 32'h700);
      rc(`OFS_SYS_CLK_STAT, 32'h700, 32'h0);
      xfer(1'b1, `OFS_PER_CLK_EN, 32'hf4);
      xfer(1'b1, `OFS_PER_CLK_DIS, 32'h14);
      rc(`OFS_PER_CLK_STAT, 32'hffff_ffff, 32'he0);
      chk("periph", 32'he0, per_en);
      // Eleven of the thirteen protected words, all but PCK1 and PCK2 config, are refused and reported with their offsets
      xfer(1'b1, `OFS_PROT_MODE, {key, 8'h01});
      for (i = 0; i < 11; i++) begin
         xfer(1'b1, pr[i], 32'hffff_ffff);
         rc(`OFS_PROT_STAT, 32'hff_ffff, {15'h0, pr[i], 8'h01});
      end
      rc(`OFS_MCK_CFG, 32'hffff_ffff, 32'h22);
      rc(`OFS_SYS_CLK_STAT, 32'h700, 32'h0);
      rc(`OFS_PER_CLK_STAT, 32'hffff_ffff, 32'he0);
      rc(`OFS_OSC_CAL, 32'hffff_ffff, `RST_OSC_CAL);
      xfer(1'b1, `OFS_PROT_MODE, {~key, 8'h00});
      rc(`OFS_PROT_STAT, 32'h1, 32'h1);
      xfer(1'b1, `OFS_PROT_MODE, {key, 8'h00});
      rc(`OFS_PROT_STAT, 32'h1, 32'h0);
      xfer(1'b1, `OFS_PER_CLK_EN, 32'h1);
      rc(`OFS_PER_CLK_STAT, 32'hffff_ffff, 32'he1);
      print_verdict();
   end
endmodule
bind clk_select clk_select_asserts clk_select_asserts_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MCK_OUT(MCK_OUT),
   .PCK_OUT(PCK_OUT), .PERIPH_CLK_EN(PERIPH_CLK_EN));
`default_nettype wire
